/* File: mfsr_fault_status.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - bit 0 mirrors live overtemperature, read-only
// - bit 1 latches channel A overcurrent; write-0 clears
// - bit 2 latches channel B overcurrent; write-0 clears
// - bit 3 mirrors live supply lockout, read-only
// - bit 4 latches channel A predriver fault; write-0 clears
// - bit 5 latches channel B predriver fault; write-0 clears
// - bit 6 live stall, bit 7 latched stall
// - defined bits reset zero; bits 11-8 reserved
module mfsr_fault_status
   import mfsr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register access port
   input wire logic [MFSR_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [MFSR_DATA_W-1:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [MFSR_DATA_W-1:0] reg_rd_data,
   output logic reg_rd_valid,
   // fault detector levels, asynchronous to clock
   input wire logic overtemp_det,
   input wire logic lockout_det,
   input wire logic oc_a_det,
   input wire logic oc_b_det,
   input wire logic pred_a_det,
   input wire logic pred_b_det,
   input wire logic stall_det,
   // drive permission per channel
   output logic chan_a_run,
   output logic chan_b_run
);
   // detector order inside both synchroniser stages
   localparam int unsigned SY_OVERTEMP = 0;
   localparam int unsigned SY_LOCKOUT = 1;
   localparam int unsigned SY_OC_A = 2;
   localparam int unsigned SY_OC_B = 3;
   localparam int unsigned SY_PRED_A = 4;
   localparam int unsigned SY_PRED_B = 5;
   localparam int unsigned SY_STALL = 6;
   localparam int unsigned NDET = SY_STALL + 1;

   typedef struct packed {
      logic [NDET-1:0] sync1;
      logic [NDET-1:0] sync2;
      logic [MFSR_DATA_W-1:0] rd_data;
      logic rd_valid;
      logic run_a;
      logic run_b;
   } mfsr_top_s;

   mfsr_top_s st_reg;
   mfsr_top_s st_next;
   mfsr_flag_if fl ();
   logic [MFSR_DATA_W-1:0] word;
   logic wr_hit;
   logic overtemp_shutdown_flag;
   logic supply_lockout_flag;
   logic stall_live_flag;
   logic chan_a_overcurrent_flag;
   logic chan_b_overcurrent_flag;
   logic chan_a_predriver_fault_flag;
   logic chan_b_predriver_fault_flag;
   logic stall_latched_flag;

   // ----------------------------------------------------------------
   // sticky flag store
   // ----------------------------------------------------------------
   mfsr_sticky_flags #(.N(MFSR_NUM_STICKY)) u_flags (
      .clock(clock),
      .rst(rst),
      .fl(fl)
   );

   // address decode used by the write path and the read path
   function automatic logic addr_hit(input logic [MFSR_ADDR_W-1:0] a);
      return a == MFSR_FAULT_STATUS_ADDR;
   endfunction

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   // live bits read only the second stage, never the metastable first one
   assign overtemp_shutdown_flag = st_reg.sync2[SY_OVERTEMP];
   assign supply_lockout_flag = st_reg.sync2[SY_LOCKOUT];
   assign stall_live_flag = st_reg.sync2[SY_STALL];
   assign chan_a_overcurrent_flag = fl.flags[MFSR_SLOT_OC_A];
   assign chan_b_overcurrent_flag = fl.flags[MFSR_SLOT_OC_B];
   assign chan_a_predriver_fault_flag = fl.flags[MFSR_SLOT_PRED_A];
   assign chan_b_predriver_fault_flag = fl.flags[MFSR_SLOT_PRED_B];
   assign stall_latched_flag = fl.flags[MFSR_SLOT_STALL];
   assign wr_hit = reg_wr_en & addr_hit(reg_addr);

   // assemble the readable word; reserved nibble is a constant
   always_comb begin
      word = MFSR_FAULT_STATUS_RESET;
      word[MFSR_BIT_OVERTEMP] = overtemp_shutdown_flag;
      word[MFSR_BIT_OC_A] = chan_a_overcurrent_flag;
      word[MFSR_BIT_OC_B] = chan_b_overcurrent_flag;
      word[MFSR_BIT_LOCKOUT] = supply_lockout_flag;
      word[MFSR_BIT_PRED_A] = chan_a_predriver_fault_flag;
      word[MFSR_BIT_PRED_B] = chan_b_predriver_fault_flag;
      word[MFSR_BIT_STALL_LIVE] = stall_live_flag;
      word[MFSR_BIT_STALL_LAT] = stall_latched_flag;
      word[MFSR_RSVD_MSB:MFSR_RSVD_LSB] = MFSR_RESERVED_VALUE;
   end

   // ----------------------------------------------------------------
   // set and clear requests to the flag store
   // ----------------------------------------------------------------
   // detectors hold their level while the fault lasts, so a flag is set
   // every cycle the condition stands; a clear then only sticks once it is gone
   always_comb begin
      fl.set = '0;
      fl.clr = '0;
      fl.set[MFSR_SLOT_OC_A] = st_reg.sync2[SY_OC_A];
      fl.set[MFSR_SLOT_OC_B] = st_reg.sync2[SY_OC_B];
      fl.set[MFSR_SLOT_PRED_A] = st_reg.sync2[SY_PRED_A];
      fl.set[MFSR_SLOT_PRED_B] = st_reg.sync2[SY_PRED_B];
      fl.set[MFSR_SLOT_STALL] = st_reg.sync2[SY_STALL];
      // only a written zero clears; ones and other bits are ignored
      fl.clr[MFSR_SLOT_OC_A] = wr_hit & ~reg_wr_data[MFSR_BIT_OC_A];
      fl.clr[MFSR_SLOT_OC_B] = wr_hit & ~reg_wr_data[MFSR_BIT_OC_B];
      fl.clr[MFSR_SLOT_PRED_A] = wr_hit & ~reg_wr_data[MFSR_BIT_PRED_A];
      fl.clr[MFSR_SLOT_PRED_B] = wr_hit & ~reg_wr_data[MFSR_BIT_PRED_B];
      fl.clr[MFSR_SLOT_STALL] = wr_hit & ~reg_wr_data[MFSR_BIT_STALL_LAT];
   end

   // ----------------------------------------------------------------
   // synchronisers, read port and run gating
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.sync1 = {stall_det, pred_b_det, pred_a_det, oc_b_det, oc_a_det,
                       lockout_det, overtemp_det};
      st_next.sync2 = st_reg.sync1;
      st_next.rd_valid = reg_rd_en;
      if (reg_rd_en) begin
         st_next.rd_data = addr_hit(reg_addr) ? word : MFSR_UNMAPPED_DATA;
      end
      // a channel stays halted until its latched faults are cleared
      st_next.run_a = ~(chan_a_overcurrent_flag | chan_a_predriver_fault_flag);
      st_next.run_b = ~(chan_b_overcurrent_flag | chan_b_predriver_fault_flag);
   end

   // one register stage holds all top state; reset zeroes read data and run
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rd_data = st_reg.rd_data;
   assign reg_rd_valid = st_reg.rd_valid;
   assign chan_a_run = st_reg.run_a;
   assign chan_b_run = st_reg.run_b;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_overtemp_live: assert property (@(posedge clock) disable iff (rst)
      (!$past(rst, 1) && !$past(rst, 2)) |-> word[MFSR_BIT_OVERTEMP] == $past(overtemp_det, 2))
      else $error("overtemp bit does not follow detector");
   chk_lockout_live: assert property (@(posedge clock) disable iff (rst)
      (!$past(rst, 1) && !$past(rst, 2)) |-> word[MFSR_BIT_LOCKOUT] == $past(lockout_det, 2))
      else $error("lockout bit does not follow detector");
   // the run output lags the flag by one register, so the halt shows a cycle later
   chk_oc_a_sets: assert property (@(posedge clock) disable iff (rst)
      st_reg.sync2[SY_OC_A] |=> word[MFSR_BIT_OC_A] ##1 !chan_a_run)
      else $error("channel A overcurrent not latched or not halted");
   chk_oc_a_clear: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && !reg_wr_data[MFSR_BIT_OC_A] && !st_reg.sync2[SY_OC_A])
      |=> !word[MFSR_BIT_OC_A])
      else $error("channel A overcurrent flag not cleared by zero write");
   chk_oc_b_sets: assert property (@(posedge clock) disable iff (rst)
      st_reg.sync2[SY_OC_B] |=> word[MFSR_BIT_OC_B] ##1 !chan_b_run)
      else $error("channel B overcurrent not latched or not halted");
   chk_oc_b_clear: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && !reg_wr_data[MFSR_BIT_OC_B] && !st_reg.sync2[SY_OC_B])
      |=> !word[MFSR_BIT_OC_B])
      else $error("channel B overcurrent flag not cleared by zero write");
   chk_pred_a_sets: assert property (@(posedge clock) disable iff (rst)
      st_reg.sync2[SY_PRED_A] |=> word[MFSR_BIT_PRED_A] ##1 !chan_a_run)
      else $error("channel A predriver fault not latched or not halted");
   chk_pred_a_clear: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && !reg_wr_data[MFSR_BIT_PRED_A] && !st_reg.sync2[SY_PRED_A])
      |=> !word[MFSR_BIT_PRED_A])
      else $error("channel A predriver flag not cleared by zero write");
   chk_pred_b_sets: assert property (@(posedge clock) disable iff (rst)
      st_reg.sync2[SY_PRED_B] |=> word[MFSR_BIT_PRED_B] ##1 !chan_b_run)
      else $error("channel B predriver fault not latched or not halted");
   chk_pred_b_set_wins: assert property (@(posedge clock) disable iff (rst)
      (st_reg.sync2[SY_PRED_B] && wr_hit && !reg_wr_data[MFSR_BIT_PRED_B])
      |=> word[MFSR_BIT_PRED_B])
      else $error("channel B predriver event lost during clear");
   chk_stall_live: assert property (@(posedge clock) disable iff (rst)
      (!$past(rst, 1) && !$past(rst, 2)) |-> word[MFSR_BIT_STALL_LIVE] == $past(stall_det, 2))
      else $error("live stall bit does not follow detector");
   chk_stall_latch: assert property (@(posedge clock) disable iff (rst)
      stall_live_flag |=> stall_latched_flag ##1 (stall_latched_flag || $past(wr_hit)))
      else $error("stall not latched");
   chk_stall_clear: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && !reg_wr_data[MFSR_BIT_STALL_LAT] && !st_reg.sync2[SY_STALL])
      |=> !word[MFSR_BIT_STALL_LAT])
      else $error("latched stall not cleared by zero write");
   chk_run_a_resume: assert property (@(posedge clock) disable iff (rst)
      (!chan_a_overcurrent_flag && !chan_a_predriver_fault_flag) |=> chan_a_run)
      else $error("channel A not released after its faults cleared");
   chk_run_b_resume: assert property (@(posedge clock) disable iff (rst)
      (!chan_b_overcurrent_flag && !chan_b_predriver_fault_flag) |=> chan_b_run)
      else $error("channel B not released after its faults cleared");
   chk_write_one_keep: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && reg_wr_data[MFSR_BIT_OC_A]) |=> $stable(word[MFSR_BIT_OC_A]) || word[MFSR_BIT_OC_A])
      else $error("writing one changed overcurrent flag");
   chk_reset_zero: assert property (@(posedge clock)
      $past(rst) |-> (word[MFSR_BIT_STALL_LAT:MFSR_BIT_OVERTEMP] == 8'h00) &&
         (word[MFSR_RSVD_MSB:MFSR_RSVD_LSB] == MFSR_RESERVED_VALUE))
      else $error("status not zero after reset");
   chk_read_data: assert property (@(posedge clock) disable iff (rst)
      (reg_rd_en && addr_hit(reg_addr)) |=> reg_rd_valid && reg_rd_data == $past(word))
      else $error("read data does not match status word");
   chk_unmapped_read: assert property (@(posedge clock) disable iff (rst)
      (reg_rd_en && !addr_hit(reg_addr)) |=> reg_rd_valid && reg_rd_data == MFSR_UNMAPPED_DATA)
      else $error("unmapped read returned wrong data");
   chk_rsvd_read: assert property (@(posedge clock) disable iff (rst)
      reg_rd_valid |-> reg_rd_data[MFSR_RSVD_MSB:MFSR_RSVD_LSB] == MFSR_RESERVED_VALUE)
      else $error("reserved bits not zero in read data");
   chk_wr_one_stall: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && reg_wr_data[MFSR_BIT_STALL_LAT]) |=> $stable(word[MFSR_BIT_STALL_LAT]) ||
         word[MFSR_BIT_STALL_LAT])
      else $error("writing one changed latched stall flag");
endmodule

/* File: mfsr_fault_status_test.sv */
`timescale 1ns/10ps
module mfsr_fault_status_test;
   import mfsr_pkg::*;
   // ------------------------------------------------------------
   // bench state
   // ------------------------------------------------------------
   localparam logic [11:0] LIVE_M = 12'h049; // bits that follow their detector
   localparam logic [11:0] CLR_M = 12'h0b6; // bits that a zero write clears
   logic clock;
   logic rst;
   logic [MFSR_ADDR_W-1:0] reg_addr;
   logic reg_wr_en;
   logic [MFSR_DATA_W-1:0] reg_wr_data;
   logic reg_rd_en;
   logic [MFSR_DATA_W-1:0] reg_rd_data;
   logic reg_rd_valid;
   logic chan_a_run;
   logic chan_b_run;
   logic [11:0] det_reg; // detector levels, laid out at their word bit positions
   logic [11:0] sticky; // bench copy of the latched flags
   logic [11:0] word;
   logic [31:0] lfsr;
   int n_errors;
   int tests_run;

   mfsr_fault_status dut_u (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid), .overtemp_det(det_reg[0]), .lockout_det(det_reg[3]),
      .oc_a_det(det_reg[1]), .oc_b_det(det_reg[2]), .pred_a_det(det_reg[4]),
      .pred_b_det(det_reg[5]), .stall_det(det_reg[6]), .chan_a_run(chan_a_run),
      .chan_b_run(chan_b_run)
   );

   // ------------------------------------------------------------
   // expectation helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // stall sets the latched copy one place up from its live bit
   function automatic logic [11:0] set_of(input logic [11:0] dw);
      return (dw & 12'h036) | {4'h0, dw[6], 7'h00};
   endfunction

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // register port tasks
   // ------------------------------------------------------------
   task automatic read_reg(input logic [3:0] a, output logic [11:0] d);
      @(posedge clock);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd_en <= 1'b0;
      #1;
      check({11'h000, reg_rd_valid}, 12'h001);
      d = reg_rd_data;
   endtask

   // a clear loses to a detector that is still high, so the model re-applies sets
   task automatic write_reg(input logic [3:0] a, input logic [11:0] d);
      @(posedge clock);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge clock);
      reg_wr_en <= 1'b0;
      if (a == MFSR_FAULT_STATUS_ADDR) begin
         sticky = (sticky & (d | ~CLR_M)) | set_of(det_reg);
      end
   endtask

   // six cycles covers the two-flop sync plus the two-cycle flag and run response
   task automatic set_det(input logic [11:0] dw);
      @(posedge clock);
      det_reg <= dw;
      sticky = sticky | set_of(dw);
      repeat (6) @(posedge clock);
   endtask

   task automatic check_all();
      read_reg(MFSR_FAULT_STATUS_ADDR, word);
      check(word, (det_reg & LIVE_M) | sticky);
      check({11'h000, chan_a_run}, {11'h000, ~(sticky[1] | sticky[4])});
      check({11'h000, chan_b_run}, {11'h000, ~(sticky[2] | sticky[5])});
   endtask

   // ------------------------------------------------------------
   // clock
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // main sequence: single flags, set-wins corner, unmapped, random, reset
   initial begin
      rst = 1'b1;
      reg_addr = '0;
      reg_wr_en = 1'b0;
      reg_wr_data = '0;
      reg_rd_en = 1'b0;
      det_reg = '0;
      sticky = '0;
      lfsr = 32'h82ea5e84;
      n_errors = 0;
      tests_run = 0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      read_reg(MFSR_FAULT_STATUS_ADDR, word);
      check(word, MFSR_FAULT_STATUS_RESET);
      for (int i = 0; i < 7; i++) begin
         set_det(12'h001 << i);
         check_all();
         set_det(12'h000);
         check_all();
         write_reg(MFSR_FAULT_STATUS_ADDR, 12'hfff);
         check_all();
         write_reg(MFSR_FAULT_STATUS_ADDR, 12'h000);
         check_all();
      end
      set_det(12'h032);
      write_reg(MFSR_FAULT_STATUS_ADDR, 12'h000);
      check_all();
      set_det(12'h000);
      write_reg(4'h3, 12'h000);
      read_reg(4'h3, word);
      check(word, MFSR_UNMAPPED_DATA);
      check_all();
      repeat (40) begin
         lfsr = next_rand(lfsr);
         set_det(lfsr[11:0] & 12'h07f);
         check_all();
         set_det(12'h000);
         lfsr = next_rand(lfsr);
         write_reg(MFSR_FAULT_STATUS_ADDR, lfsr[11:0]);
         check_all();
      end
      set_det(12'h076);
      set_det(12'h000);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      sticky = '0;
      check_all();
      end_of_test();
   end
endmodule

/* File: mfsr_flag_if.sv */
`timescale 1ns/10ps
// carries set, clear and the held flags between the top and the flag store
interface mfsr_flag_if;
   import mfsr_pkg::*;
   mfsr_sticky_t set;
   mfsr_sticky_t clr;
   mfsr_sticky_t flags;
   modport store (input set, input clr, output flags);
   modport user (output set, output clr, input flags);
endinterface

/* File: mfsr_pkg.sv */
package mfsr_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int unsigned MFSR_ADDR_W = 4;
   localparam int unsigned MFSR_DATA_W = 12;
   localparam logic [MFSR_ADDR_W-1:0] MFSR_FAULT_STATUS_ADDR = 4'h7;
   localparam logic [MFSR_DATA_W-1:0] MFSR_FAULT_STATUS_RESET = 12'h000;
   localparam logic [MFSR_DATA_W-1:0] MFSR_UNMAPPED_DATA = 12'h000;
   localparam logic [3:0] MFSR_RESERVED_VALUE = 4'h0;

   // ----------------------------------------------------------------
   // bit positions in fault_status
   // ----------------------------------------------------------------
   localparam int unsigned MFSR_BIT_OVERTEMP = 0;
   localparam int unsigned MFSR_BIT_OC_A = 1;
   localparam int unsigned MFSR_BIT_OC_B = 2;
   localparam int unsigned MFSR_BIT_LOCKOUT = 3;
   localparam int unsigned MFSR_BIT_PRED_A = 4;
   localparam int unsigned MFSR_BIT_PRED_B = 5;
   localparam int unsigned MFSR_BIT_STALL_LIVE = 6;
   localparam int unsigned MFSR_BIT_STALL_LAT = 7;
   localparam int unsigned MFSR_RSVD_LSB = 8;
   localparam int unsigned MFSR_RSVD_MSB = 11;

   // ----------------------------------------------------------------
   // sticky flag slots inside the flag store
   // ----------------------------------------------------------------
   localparam int unsigned MFSR_NUM_STICKY = 5;
   localparam int unsigned MFSR_SLOT_OC_A = 0;
   localparam int unsigned MFSR_SLOT_OC_B = 1;
   localparam int unsigned MFSR_SLOT_PRED_A = 2;
   localparam int unsigned MFSR_SLOT_PRED_B = 3;
   localparam int unsigned MFSR_SLOT_STALL = 4;

   typedef logic [MFSR_NUM_STICKY-1:0] mfsr_sticky_t;
endpackage

/* File: mfsr_sticky_flags.sv */
`timescale 1ns/10ps
module mfsr_sticky_flags
   import mfsr_pkg::*;
#(
   parameter int unsigned N = MFSR_NUM_STICKY
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // flag traffic
   mfsr_flag_if.store fl
);
   typedef struct packed {
      logic [N-1:0] flag;
   } mfsr_store_s;

   mfsr_store_s st_reg;
   mfsr_store_s st_next;

   // ----------------------------------------------------------------
   // per-flag next state
   // ----------------------------------------------------------------
   // a detector event in the clearing cycle wins so no fault is lost
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < N; i++) begin
         st_next.flag[i] = fl.set[i] | (st_reg.flag[i] & ~fl.clr[i]);
      end
   end

   // reset empties every flag
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fl.flags = st_reg.flag;
endmodule
